// ===== ufic_params.svh
`ifndef UFIC_PARAMS_SVH
`define UFIC_PARAMS_SVH
// ==========================================================================
// storage geometry
`define UFIC_PTR_W 4
`define UFIC_DEPTH 5'h10
`define UFIC_ONE_SLOT 5'h01
// ==========================================================================
// register offsets
`define UFIC_OFF_DATA 3'h0
`define UFIC_OFF_IER 3'h1
`define UFIC_OFF_QCTL 3'h2
// ==========================================================================
// irq_enable_mask fields and reset value
`define UFIC_IER_RDA 0
`define UFIC_IER_THRE 1
`define UFIC_IER_LS 2
`define UFIC_IER_MS 3
`define UFIC_IER_RST 4'h0
// ==========================================================================
// queue_control fields and reset value
`define UFIC_QC_EN 0
`define UFIC_QC_RXCLR 1
`define UFIC_QC_TXCLR 2
`define UFIC_QC_TRIG_LO 6
`define UFIC_QC_TRIG_HI 7
`define UFIC_TRIG_RST 2'h0
// ==========================================================================
// receive trigger levels in bytes
`define UFIC_TRIG_1 5'h01
`define UFIC_TRIG_4 5'h04
`define UFIC_TRIG_8 5'h08
`define UFIC_TRIG_14 5'h0E
// ==========================================================================
// irq_source_id source codes
`define UFIC_ID_NONE 4'h1
`define UFIC_ID_LS 4'h6
`define UFIC_ID_RDA 4'h4
`define UFIC_ID_TO 4'hC
`define UFIC_ID_THRE 4'h2
`define UFIC_ID_MS 4'h0
// ==========================================================================
// timing in bit ticks
`define UFIC_CHAR_BITS 10
`define UFIC_TO_CHARS 4
`define UFIC_TO_TICKS 6'(`UFIC_CHAR_BITS * `UFIC_TO_CHARS)
`define UFIC_TX_FRAME 4'hA
`define UFIC_RX_LAST 3'h7
`endif

// ===== ufic_pkg.sv
`include "ufic_params.svh"
// ==========================================================================
// shared types
package ufic_pkg;
    typedef logic [7:0] ufic_byte_t; // one character
    typedef logic [`UFIC_PTR_W-1:0] ufic_ptr_t; // storage slot index
    typedef logic [`UFIC_PTR_W:0] ufic_cnt_t; // fill level, 0..16
    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} ufic_rx_st_e; // receive shifter
    typedef enum logic {TX_IDLE, TX_SHIFT} ufic_tx_st_e; // transmit shifter
endpackage

// ===== ufic_mem_if.sv
// ==========================================================================
// storage port between the core and one character memory
interface ufic_mem_if;
    import ufic_pkg::*;
    logic we; // write enable
    ufic_ptr_t waddr; // write slot
    ufic_byte_t wdata; // write character
    ufic_ptr_t raddr; // read slot
    ufic_byte_t rdata; // registered read character
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ===== ufic_mem.sv
// ==========================================================================
// sixteen character store, read data from a register with write bypass
module ufic_mem
    import ufic_pkg::*;
(
    input wire logic ref_clk,
    ufic_mem_if.mem port
);
    ufic_byte_t store_r [0:`UFIC_DEPTH-1]; // character slots

    // write port
    always_ff @(posedge ref_clk) begin
        if (port.we) begin
            store_r[port.waddr] <= port.wdata;
        end
    end

    // read register: a same-edge write to the read slot is passed through
    always_ff @(posedge ref_clk) begin
        if (port.we && (port.waddr == port.raddr)) begin
            port.rdata <= port.wdata;
        end else begin
            port.rdata <= store_r[port.raddr];
        end
    end
endmodule

// ===== ufic_core.sv
// Operation
// - data travels least significant bit first
// - receive shifter feeds holding register at 0
// - transmit shifter loads after previous byte done
// - enable bit0 data/timeout, bit1 transmit empty
// - enable bit2 gates line status interrupt
// - enable bit3 modem status; bits 7:4 zero
// - no enables means no identification or output
// - queue enable bit; clearing empties both queues
// - bit1 flushes receive queue, shifter kept
// - bit2 flushes transmit queue, shifter kept
// - bit3 inert; bits 5:4 reserved
// - bits 7:6 pick trigger 1/4/8/14
// - report highest: line, data, empty, modem
// - identification stays stable during its read
// - id bit0 low when something pending
// - id source codes 1,6,4,C,2,0
// - id bit3 only for timeout in queue mode
// - id bits 7:6 follow queue enable; 5:4 zero
// - timeout after four idle character times
// - data interrupt drops on read or below trigger
// - empty interrupt clears on id read or write
// - divisor latch select steers offsets 0 and 1
// - interrupt output driven only when gate set
`include "ufic_params.svh"
module ufic_core
    import ufic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic divisor_latch_select,
    input wire logic irq_output_gate,
    input wire logic line_status_pending,
    input wire logic modem_status_pending,
    input wire logic bit_tick,
    input wire logic serial_in,
    output logic serial_out,
    output logic rx_overrun,
    output logic irq_out,
    output logic irq_oe
);
    // ======================================================================
    // decode helper
    // true when the access hits offset off; data and enable need latch select low
    function automatic logic reg_hit(input logic [2:0] addr, input logic [2:0] off,
                                     input logic dls);
        reg_hit = (addr == off) && ((off == `UFIC_OFF_QCTL) || !dls);
    endfunction

    // ======================================================================
    // declarations
    ufic_mem_if tx_mif (); // transmit store port
    ufic_mem_if rx_mif (); // receive store port

    logic [3:0] ier_r; // irq_enable_mask bits 3:0
    logic fifo_en_r; // queue mode on
    logic [1:0] trig_r; // receive trigger select
    logic thre_pend_r; // transmit empty interrupt pending
    logic [5:0] to_cnt_r; // idle bit ticks for timeout
    logic [7:0] reg_rdata_r; // read data register
    logic serial_out_r; // line output register
    logic rx_overrun_r; // overrun pulse register
    logic irq_out_r; // interrupt output register
    logic irq_oe_r; // interrupt enable-to-drive register

    ufic_ptr_t tx_head_r, tx_tail_r; // transmit read / write slots
    ufic_cnt_t tx_cnt_r; // transmit fill
    ufic_ptr_t rx_head_r, rx_tail_r; // receive read / write slots
    ufic_cnt_t rx_cnt_r; // receive fill

    ufic_tx_st_e tx_st_r; // transmit shifter state
    logic [9:0] tx_sh_r; // start, data, stop frame
    logic [3:0] tx_bits_r; // frame bits still to send
    ufic_rx_st_e rx_st_r; // receive shifter state
    ufic_byte_t rx_sh_r; // assembling character
    logic [2:0] rx_bits_r; // data bit index

    // ======================================================================
    // access decode
    wire wr_data = reg_wr && reg_hit(reg_addr, `UFIC_OFF_DATA, divisor_latch_select);
    wire rd_data = reg_rd && reg_hit(reg_addr, `UFIC_OFF_DATA, divisor_latch_select);
    wire wr_ier = reg_wr && reg_hit(reg_addr, `UFIC_OFF_IER, divisor_latch_select);
    wire rd_ier = reg_rd && reg_hit(reg_addr, `UFIC_OFF_IER, divisor_latch_select);
    wire wr_qctl = reg_wr && reg_hit(reg_addr, `UFIC_OFF_QCTL, divisor_latch_select);
    wire rd_iir = reg_rd && reg_hit(reg_addr, `UFIC_OFF_QCTL, divisor_latch_select);

    // ======================================================================
    // queue control decode
    wire qc_en = reg_wdata[`UFIC_QC_EN]; // new mode bit
    wire mode_flip = wr_qctl && (qc_en != fifo_en_r); // any mode change empties queues
    // other bits act only alongside bit0 set; bit3 and bits 5:4 are ignored
    wire rx_flush = mode_flip || (wr_qctl && qc_en && reg_wdata[`UFIC_QC_RXCLR]);
    wire tx_flush = mode_flip || (wr_qctl && qc_en && reg_wdata[`UFIC_QC_TXCLR]);
    wire [1:0] trig_nxt = {reg_wdata[`UFIC_QC_TRIG_HI], reg_wdata[`UFIC_QC_TRIG_LO]};

    // ======================================================================
    // capacity: sixteen in queue mode, a single holding slot otherwise
    wire ufic_cnt_t cap = fifo_en_r ? `UFIC_DEPTH : `UFIC_ONE_SLOT;
    wire tx_full = (tx_cnt_r == cap);
    wire tx_empty = (tx_cnt_r == '0);
    wire rx_full = (rx_cnt_r == cap);
    wire rx_empty = (rx_cnt_r == '0);

    // ======================================================================
    // transmit queue moves
    wire tx_push = wr_data && !tx_full && !tx_flush; // full queue drops the write
    wire tx_pop = bit_tick && (tx_st_r == TX_IDLE) && !tx_empty && !tx_flush;

    // ======================================================================
    // receive queue moves
    wire rx_done = bit_tick && (rx_st_r == RX_STOP); // character complete
    wire rx_over = rx_done && rx_full; // no free slot
    // non-queue mode overwrites the unread character, queue mode drops it
    wire rx_push = rx_done && !rx_flush && (!rx_full || !fifo_en_r);
    wire rx_adv = rx_push && !rx_full; // push that takes a new slot
    wire rx_pop = rd_data && !rx_empty && !rx_flush;

    // ======================================================================
    // interrupt sources
    wire ufic_cnt_t trig_lvl = (trig_r == 2'h0) ? `UFIC_TRIG_1 :
                               (trig_r == 2'h1) ? `UFIC_TRIG_4 :
                               (trig_r == 2'h2) ? `UFIC_TRIG_8 : `UFIC_TRIG_14;
    wire rda_lvl = fifo_en_r ? (rx_cnt_r >= trig_lvl) : !rx_empty;
    wire timeout = fifo_en_r && (to_cnt_r == `UFIC_TO_TICKS);
    wire src_ls = ier_r[`UFIC_IER_LS] && line_status_pending;
    wire src_rda = ier_r[`UFIC_IER_RDA] && rda_lvl;
    wire src_to = ier_r[`UFIC_IER_RDA] && timeout;
    wire src_thre = ier_r[`UFIC_IER_THRE] && thre_pend_r;
    wire src_ms = ier_r[`UFIC_IER_MS] && modem_status_pending;
    // priority chain, highest first; with no enables every source is gated off
    wire [3:0] id_code = src_ls ? `UFIC_ID_LS :
                         src_rda ? `UFIC_ID_RDA :
                         src_to ? `UFIC_ID_TO :
                         src_thre ? `UFIC_ID_THRE :
                         src_ms ? `UFIC_ID_MS : `UFIC_ID_NONE;
    wire irq_pending = !id_code[0];
    // bits 7:6 mirror the mode, bits 5:4 zero
    wire [7:0] iir_val = {fifo_en_r, fifo_en_r, 2'b00, id_code};

    // ======================================================================
    // transmit empty events
    wire thre_set = (tx_pop && (tx_cnt_r == `UFIC_ONE_SLOT))
                    || (tx_flush && !tx_empty)
                    || (wr_ier && reg_wdata[`UFIC_IER_THRE] && !ier_r[`UFIC_IER_THRE] && tx_empty);
    // the read snapshot and this clear use the same code, so they agree
    wire thre_clr = wr_data || (rd_iir && (id_code == `UFIC_ID_THRE));

    // ======================================================================
    // read mux: reserved and foreign offsets read zero
    wire [7:0] rd_mux = rd_data ? rx_mif.rdata :
                        rd_ier ? {4'h0, ier_r} :
                        rd_iir ? iir_val : 8'h00;

    // ======================================================================
    // storage ports
    assign tx_mif.we = tx_push;
    assign tx_mif.waddr = tx_tail_r;
    assign tx_mif.wdata = reg_wdata;
    assign tx_mif.raddr = tx_head_r;
    assign rx_mif.we = rx_push;
    assign rx_mif.waddr = rx_full ? rx_head_r : rx_tail_r;
    assign rx_mif.wdata = rx_sh_r;
    assign rx_mif.raddr = rx_pop ? rx_head_r + 1'b1 : rx_head_r; // next head after a pop

    ufic_mem u_tx_mem (
        .ref_clk(ref_clk),
        .port(tx_mif.mem)
    );

    ufic_mem u_rx_mem (
        .ref_clk(ref_clk),
        .port(rx_mif.mem)
    );

    // ======================================================================
    // software registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ier_r <= `UFIC_IER_RST;
            fifo_en_r <= 1'b0;
            trig_r <= `UFIC_TRIG_RST;
        end else begin
            if (wr_ier) begin
                ier_r <= reg_wdata[3:0];
            end
            if (wr_qctl) begin
                fifo_en_r <= qc_en;
            end
            if (wr_qctl && qc_en) begin
                trig_r <= trig_nxt;
            end
        end
    end

    // ======================================================================
    // transmit queue pointers
    always_ff @(posedge ref_clk) begin
        if (sys_rst || tx_flush) begin
            tx_head_r <= '0;
            tx_tail_r <= '0;
            tx_cnt_r <= '0;
        end else begin
            if (tx_push) begin
                tx_tail_r <= tx_tail_r + 1'b1;
            end
            if (tx_pop) begin
                tx_head_r <= tx_head_r + 1'b1;
            end
            tx_cnt_r <= tx_cnt_r + ufic_cnt_t'(tx_push) - ufic_cnt_t'(tx_pop);
        end
    end

    // ======================================================================
    // receive queue pointers
    always_ff @(posedge ref_clk) begin
        if (sys_rst || rx_flush) begin
            rx_head_r <= '0;
            rx_tail_r <= '0;
            rx_cnt_r <= '0;
        end else begin
            if (rx_adv) begin
                rx_tail_r <= rx_tail_r + 1'b1;
            end
            if (rx_pop) begin
                rx_head_r <= rx_head_r + 1'b1;
            end
            rx_cnt_r <= rx_cnt_r + ufic_cnt_t'(rx_adv) - ufic_cnt_t'(rx_pop);
        end
    end

    // ======================================================================
    // transmit shifter, never touched by a flush
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tx_st_r <= TX_IDLE;
            tx_sh_r <= '1;
            tx_bits_r <= '0;
            serial_out_r <= 1'b1;
        end else begin
            case (tx_st_r)
                TX_IDLE: begin
                    if (tx_pop) begin
                        tx_sh_r <= {1'b1, tx_mif.rdata, 1'b0};
                        tx_bits_r <= `UFIC_TX_FRAME;
                        tx_st_r <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (bit_tick) begin
                        serial_out_r <= tx_sh_r[0];
                        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                        tx_bits_r <= tx_bits_r - 1'b1;
                        if (tx_bits_r == 4'h1) begin
                            tx_st_r <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_st_r <= TX_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // receive shifter: start, eight data bits, stop
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rx_st_r <= RX_IDLE;
            rx_sh_r <= '0;
            rx_bits_r <= '0;
        end else if (bit_tick) begin
            case (rx_st_r)
                RX_IDLE: begin
                    if (!serial_in) begin
                        rx_bits_r <= '0;
                        rx_st_r <= RX_DATA;
                    end
                end
                RX_DATA: begin
                    rx_sh_r <= {serial_in, rx_sh_r[7:1]};
                    rx_bits_r <= rx_bits_r + 1'b1;
                    if (rx_bits_r == `UFIC_RX_LAST) begin
                        rx_st_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    rx_st_r <= RX_IDLE;
                end
                default: begin
                    rx_st_r <= RX_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // character timeout: any queue activity or an empty queue restarts it
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !fifo_en_r || rx_empty || rx_push || rx_pop || rx_flush) begin
            to_cnt_r <= '0;
        end else if (bit_tick && (to_cnt_r != `UFIC_TO_TICKS)) begin
            to_cnt_r <= to_cnt_r + 1'b1;
        end
    end

    // ======================================================================
    // transmit empty pending, a set beats a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            thre_pend_r <= 1'b0;
        end else begin
            thre_pend_r <= thre_set || (thre_pend_r && !thre_clr);
        end
    end

    // ======================================================================
    // output registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata_r <= 8'h00;
            rx_overrun_r <= 1'b0;
            irq_out_r <= 1'b0;
            irq_oe_r <= 1'b0;
        end else begin
            reg_rdata_r <= rd_mux;
            rx_overrun_r <= rx_over;
            irq_out_r <= irq_output_gate && irq_pending;
            irq_oe_r <= irq_output_gate;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign serial_out = serial_out_r;
    assign rx_overrun = rx_overrun_r;
    assign irq_out = irq_out_r;
    assign irq_oe = irq_oe_r;
endmodule

// ===== ufic_core_props.sv
// ==========================================================================
// port checker for the core
module ufic_core_props (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic divisor_latch_select,
    input wire logic irq_output_gate,
    input wire logic line_status_pending,
    input wire logic modem_status_pending,
    input wire logic bit_tick,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic rx_overrun,
    input wire logic irq_out,
    input wire logic irq_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================================
    // read strobes of interest
    sequence id_rd;
        reg_rd && reg_addr == 3'h2;
    endsequence
    sequence mask_rd;
        reg_rd && reg_addr == 3'h1 && !divisor_latch_select;
    endsequence
    sequence hidden_rd;
        reg_rd && reg_addr < 3'h2 && divisor_latch_select;
    endsequence
    // ==========================================================================
    // read path
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    mask_upper_a: assert property (mask_rd |=> reg_rdata[7:4] == 4'h0)
        else $error("enable mask upper bits set");
    dls_hide_a: assert property (hidden_rd |=> reg_rdata == 8'h00)
        else $error("hidden offset returned data");
    id_fixed_a: assert property (
        id_rd |=> reg_rdata[5:4] == 2'h0 && reg_rdata[7] == reg_rdata[6])
        else $error("identification fixed bits wrong");
    id_timeout_a: assert property (id_rd |=> reg_rdata[7] || !reg_rdata[3])
        else $error("timeout code outside queue mode");
    id_code_a: assert property (
        id_rd |=> reg_rdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2, 4'h0})
        else $error("unknown identification code");
    // ==========================================================================
    // interrupt pin and serial line
    oe_follow_a: assert property (1'h1 |=> irq_oe == $past(irq_output_gate))
        else $error("pin enable does not follow gate");
    irq_gate_a: assert property (irq_out |-> irq_oe)
        else $error("interrupt raised while pin disabled");
    tx_hold_a: assert property (!bit_tick |=> $stable(serial_out))
        else $error("serial output moved off a bit time");
endmodule
bind ufic_core ufic_core_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .divisor_latch_select(divisor_latch_select),
    .irq_output_gate(irq_output_gate), .line_status_pending(line_status_pending),
    .modem_status_pending(modem_status_pending), .bit_tick(bit_tick),
    .serial_in(serial_in), .serial_out(serial_out), .rx_overrun(rx_overrun),
    .irq_out(irq_out), .irq_oe(irq_oe));

// ===== ufic_line_model.sv
// ==========================================================================
// far end of the serial line: sends frames in, decodes frames out
module ufic_line_model (
    input wire logic ref_clk,
    input wire logic bit_tick,
    input wire logic serial_out,
    output logic serial_in,
    output logic got_v,
    output logic [7:0] got_b
);
    logic [3:0] cnt_r = 4'h0; // bits left in frame, 0 = idle
    logic [7:0] sh_r = 8'h00; // data gathered so far
    initial serial_in = 1'h1; // line rests at mark
    initial got_v = 1'h0;
    // one frame after a gap of 0..3 bit times, start, data lsb first, stop
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'h1, b, 1'h0};
        repeat (b[1:0]) @(posedge ref_clk iff bit_tick);
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk iff bit_tick);
            serial_in <= fr[i];
        end
        @(posedge ref_clk iff bit_tick);
    endtask
    // decode the core's output once per bit time
    always @(posedge ref_clk) begin
        got_v <= 1'h0;
        if (bit_tick && cnt_r == 4'h0) begin
            if (!serial_out) cnt_r <= 4'h9; // start bit seen
        end else if (bit_tick) begin
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
                got_v <= serial_out; // only a high stop bit counts
                got_b <= sh_r;
            end else begin
                sh_r <= {serial_out, sh_r[7:1]};
            end
        end
    end
endmodule

// ===== testbench.sv
// ==========================================================================
// self-checking bench for the core
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic divisor_latch_select = 1'h0, irq_output_gate = 1'h1, bit_tick = 1'h0;
    logic line_status_pending = 1'h0, modem_status_pending = 1'h0, rd_d = 1'h0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, got_b;
    logic serial_in, serial_out, rx_overrun, irq_out, irq_oe, got_v;
    logic [7:0] exp_q[$], tx_q[$], b[$]; // read notes, sent bytes, fed bytes
    logic [1:0] div = 2'h0; // bit time divider
    int n_fail = 0, checks = 0, cyc = 0, seed = 79148, n_ovr = 0;
    int lv[4] = '{1, 4, 8, 14}; // trigger levels in bytes
    always #50 ref_clk = ~ref_clk;
    // one bit time every fourth clock
    always @(posedge ref_clk) begin
        div <= div + 2'h1;
        bit_tick <= (div == 2'h3);
    end
    ufic_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .divisor_latch_select(divisor_latch_select), .irq_output_gate(irq_output_gate),
        .line_status_pending(line_status_pending), .bit_tick(bit_tick),
        .modem_status_pending(modem_status_pending), .serial_in(serial_in),
        .serial_out(serial_out), .rx_overrun(rx_overrun), .irq_out(irq_out), .irq_oe(irq_oe));
    ufic_line_model u_line (.ref_clk(ref_clk), .bit_tick(bit_tick), .serial_out(serial_out),
        .serial_in(serial_in), .got_v(got_v), .got_b(got_b));
    // ==========================================================================
    // helpers
    task automatic finish_test();
        if (n_fail == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask
    // one bus cycle; a read notes d as its expected data
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w) exp_q.push_back(d);
    endtask
    // drop strobes, then wait n cycles
    task automatic idle(input int n);
        @(posedge ref_clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        repeat (n) @(posedge ref_clk);
    endtask
    // feed n random characters over the line
    task automatic rx_send(input int n);
        logic [7:0] v;
        repeat (n) begin
            v = 8'($random(seed));
            b.push_back(v);
            u_line.send(v);
        end
    endtask
    // write n random characters for transmission
    task automatic tx_put(input int n);
        logic [7:0] v;
        repeat (n) begin
            v = 8'($random(seed));
            tx_q.push_back(v);
            bus(1'h1, 3'h0, v);
        end
    endtask
    // bounded wait until every sent byte came out
    task automatic drain();
        for (int i = 0; i < 600 && tx_q.size() > 0; i++) @(posedge ref_clk);
        idle(60);
    endtask
    // ==========================================================================
    // watcher: read data and line bytes against the oldest note
    always @(posedge ref_clk) begin
        rd_d <= reg_rd;
        if (rx_overrun) n_ovr++;
        if (rd_d) chk(reg_rdata, exp_q.pop_front());
        if (got_v) chk(got_b, tx_q.size() > 0 ? tx_q.pop_front() : 8'hXX);
        cyc++;
        if (cyc == 8000) begin
            n_fail++;
            finish_test();
        end
    end
    // ==========================================================================
    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'h0;
        bus(1'h0, 3'h1, 8'h00);
        bus(1'h0, 3'h2, 8'h01);
        bus(1'h0, 3'h5, 8'h00);
        divisor_latch_select <= 1'h1;
        bus(1'h1, 3'h1, 8'h0F);
        bus(1'h0, 3'h1, 8'h00);
        idle(0);
        divisor_latch_select <= 1'h0;
        bus(1'h0, 3'h1, 8'h00);
        bus(1'h1, 3'h1, 8'hFF);
        bus(1'h0, 3'h1, 8'h0F);
        bus(1'h0, 3'h2, 8'h02);
        bus(1'h0, 3'h2, 8'h01);
        idle(0);
        modem_status_pending <= 1'h1;
        bus(1'h0, 3'h2, 8'h00);
        idle(0);
        line_status_pending <= 1'h1;
        bus(1'h0, 3'h2, 8'h06);
        bus(1'h1, 3'h1, 8'h00);
        bus(1'h0, 3'h2, 8'h01);
        idle(3);
        chk({6'h00, irq_oe, irq_out}, 8'h02);
        bus(1'h1, 3'h1, 8'h04);
        idle(3);
        chk({6'h00, irq_oe, irq_out}, 8'h03);
        irq_output_gate <= 1'h0;
        idle(3);
        chk({6'h00, irq_oe, irq_out}, 8'h00);
        irq_output_gate <= 1'h1;
        line_status_pending <= 1'h0;
        modem_status_pending <= 1'h0;
        bus(1'h1, 3'h1, 8'h05);
        // each trigger level: one byte short, then at the level
        for (int k = 0; k < 4; k++) begin
            b.delete();
            bus(1'h1, 3'h2, {2'(k), 6'h3B});
            bus(1'h0, 3'h2, 8'hC1);
            idle(0);
            rx_send(lv[k] - 1);
            bus(1'h0, 3'h2, 8'hC1);
            idle(0);
            rx_send(1);
            bus(1'h0, 3'h2, 8'hC4);
            bus(1'h0, 3'h0, b[0]);
            bus(1'h0, 3'h2, 8'hC1);
        end
        idle(140);
        bus(1'h0, 3'h2, 8'hC1);
        idle(30);
        bus(1'h0, 3'h2, 8'hCC);
        bus(1'h0, 3'h0, b[1]);
        bus(1'h0, 3'h0, b[2]);
        bus(1'h0, 3'h2, 8'hC1);
        bus(1'h1, 3'h1, 8'h02);
        bus(1'h0, 3'h2, 8'hC2);
        tx_put(3);
        bus(1'h0, 3'h2, 8'hC1);
        idle(0);
        drain();
        bus(1'h0, 3'h2, 8'hC2);
        tx_put(2);
        idle(8);
        bus(1'h1, 3'h2, 8'h05);
        void'(tx_q.pop_back());
        idle(0);
        drain();
        bus(1'h1, 3'h2, 8'h00);
        bus(1'h1, 3'h1, 8'h01);
        bus(1'h0, 3'h2, 8'h01);
        idle(0);
        b.delete();
        rx_send(1);
        bus(1'h0, 3'h2, 8'h04);
        bus(1'h0, 3'h0, b[0]);
        bus(1'h0, 3'h2, 8'h01);
        idle(0);
        b.delete();
        rx_send(2);
        bus(1'h0, 3'h0, b[1]);
        idle(4);
        chk(8'(n_ovr), 8'h01);
        finish_test();
    end
endmodule
